/* include/afe_consts.svh */
// Purpose: Register addresses, reset values, field codes and counts
// Assumes: 6-bit register address space, 8-bit data
// Notes:   Definitions only
`ifndef AFE_CONSTS_SVH
`define AFE_CONSTS_SVH

`define AFE_ADDR_FMT      6'h02
`define AFE_ADDR_CLAMP    6'h03
`define AFE_ADDR_SRST     6'h04
`define AFE_ADDR_CYCRST   6'h05
`define AFE_ADDR_LSEQ     6'h06

`define AFE_FMT_RESET     8'h20
`define AFE_CLAMP_RESET   8'h1F
`define AFE_LSEQ_RESET    8'h00
`define AFE_READ_ZERO     8'h00

`define AFE_COL_RED       2'h0
`define AFE_COL_GREEN     2'h1
`define AFE_COL_BLUE      2'h2

`define AFE_OF_8P6_A      2'h0
`define AFE_OF_8P6_B      2'h1
`define AFE_OF_7P7        2'h2
`define AFE_OF_4P4P4P2    2'h3

`define AFE_PER_NORMAL    2'h2
`define AFE_PER_MODE3     2'h3

`define AFE_CDS_ADVANCE1  2'h0
`define AFE_CDS_NORMAL    2'h1
`define AFE_CDS_RETARD1   2'h2
`define AFE_CDS_RETARD2   2'h3

`define AFE_PIECE_LAST2   2'h1
`define AFE_PIECE_LAST4   2'h3
`define AFE_TAP_DEPTH     9

`endif

/* include/afe_pkg.sv */
// Purpose: Shared types of the front-end setup control block
// Assumes: Field layouts follow the register bit order, msb first
// Notes:   Constants live in afe_consts.svh
package afe_pkg;

    typedef logic [1:0] afe_colour_t;

    typedef struct packed {
        logic [1:0] latency;
        logic       dac_range;
        logic       rsvd;
        logic       ref_external;
        logic       invert;
        logic [1:0] format_sel;
    } afe_fmt_s;

    typedef struct packed {
        afe_colour_t mono_pick;
        logic [1:0]  cds_adjust;
        logic [3:0]  dac_code;
    } afe_clamp_s;

    typedef struct packed {
        afe_colour_t forced_colour;
        afe_colour_t internal_colour;
        logic        internal_clamp;
        logic        forced_mux;
        logic        autocycle;
        logic        line_seq;
    } afe_lseq_s;

    typedef struct packed {
        logic [1:0]  format_sel;
        logic        invert;
        logic        dac_power_down;
        logic        dac_drive_en;
        logic        dac_range;
        logic [3:0]  dac_code;
        logic [1:0]  latency;
        logic [1:0]  adc_period;
        logic [1:0]  cds_adjust;
        logic        mono_eff;
        afe_colour_t mono_pick_eff;
        logic        gb_pga_off;
        logic        pin_is_clamp;
        logic        clamp_en;
        afe_colour_t input_mux;
        afe_colour_t gain_mux;
    } afe_ctrl_s;

    typedef struct packed {
        logic       valid;
        logic [13:0] code;
    } afe_sample_s;

endpackage

/* src/afe_bit_sync.sv */
// Purpose: Two-stage synchroniser for one pin level
// Assumes: Pin is asynchronous to clk_i
// Notes:   First stage feeds only the second
`timescale 1ns/1ps
`include "afe_consts.svh"
module afe_bit_sync
    import afe_pkg::*;
(
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic reset_i,
    // Pin level
    input  wire logic pin_i,
    output logic      level_o
);
    typedef struct packed {
        logic s1;
        logic s2;
    } afe_sync_s;

    afe_sync_s st_q;
    afe_sync_s st_d;

    always_comb begin
        st_d    = st_q;
        st_d.s1 = pin_i;
        st_d.s2 = st_q.s1;
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign level_o = st_q.s2;
endmodule

/* src/afe_output_pipe.sv */
// Purpose: Output polarity, latency delay and multiplexed word format
// Assumes: One sample pulse per converter period
// Notes:   Pieces are MSB aligned on the 8-bit output
`timescale 1ns/1ps
`include "afe_consts.svh"
module afe_output_pipe
    import afe_pkg::*;
#(
    parameter int DEPTH = `AFE_TAP_DEPTH
)(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Controls
    input  wire logic        invert_i,
    input  wire logic [1:0]  latency_i,
    input  wire logic [1:0]  period_i,
    input  wire logic [1:0]  format_i,
    // Converted sample
    input  wire afe_sample_s sample_i,
    // Output word
    output logic [7:0]       data_o,
    output logic             valid_o,
    output logic             first_o
);
    typedef struct packed {
        afe_sample_s [DEPTH-1:0] pipe;
        logic [13:0]             word;
        logic [1:0]              piece;
        logic                    busy;
        logic [7:0]              data;
        logic                    valid;
        logic                    first;
    } afe_pipe_s;

    afe_pipe_s st_q;
    afe_pipe_s st_d;

    function automatic logic [3:0] tap_of(input logic [1:0] lat, input logic [1:0] per);
        tap_of = 4'({2'h0, lat} * {2'h0, per});
    endfunction

    function automatic logic [7:0] piece_of(input logic [13:0] c, input logic [1:0] f,
                                            input logic [1:0] i);
        piece_of = 8'h00;
        if (f == `AFE_OF_7P7) begin
            piece_of = (i == 2'h0) ? {c[13:7], 1'b0} : {c[6:0], 1'b0};
        end else if (f == `AFE_OF_4P4P4P2) begin
            case (i)
                2'h0:    piece_of = {c[13:10], 4'h0};
                2'h1:    piece_of = {c[9:6], 4'h0};
                2'h2:    piece_of = {c[5:2], 4'h0};
                default: piece_of = {c[1:0], 6'h00};
            endcase
        end else begin
            piece_of = (i == 2'h0) ? c[13:6] : {c[5:0], 2'h0};
        end
    endfunction

    always_comb begin
        afe_sample_s in_s;
        afe_sample_s tap_s;
        logic [3:0]  tap;
        logic [1:0]  last;
        in_s       = sample_i;
        tap_s      = '0;
        tap        = '0;
        last       = '0;
        st_d       = st_q;
        if (invert_i) begin
            in_s.code = ~sample_i.code; // [R2]
        end
        st_d.pipe[0] = in_s;
        for (int k = 1; k < DEPTH; k++) begin
            st_d.pipe[k] = st_q.pipe[k-1];
        end
        tap = tap_of(latency_i, period_i); // [R5] [R6]
        if (tap == 4'h0) begin
            tap_s = in_s;
        end else begin
            tap_s = st_q.pipe[tap - 4'h1];
        end
        last = (format_i == `AFE_OF_4P4P4P2) ? `AFE_PIECE_LAST4 : `AFE_PIECE_LAST2; // [R1]
        st_d.valid = 1'b0;
        st_d.first = 1'b0;
        if (tap_s.valid) begin
            st_d.word  = tap_s.code;
            st_d.piece = 2'h1;
            st_d.busy  = 1'b1;
            st_d.data  = piece_of(tap_s.code, format_i, 2'h0); // [R1]
            st_d.valid = 1'b1;
            st_d.first = 1'b1;
        end else if (st_q.busy) begin
            st_d.data  = piece_of(st_q.word, format_i, st_q.piece);
            st_d.valid = 1'b1;
            st_d.piece = st_q.piece + 2'h1;
            st_d.busy  = (st_q.piece != last);
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign data_o  = st_q.data;
    assign valid_o = st_q.valid;
    assign first_o = st_q.first;
endmodule

/* src/afe_setup_control_regs.sv */
// Purpose: Setup registers and derived controls of an imaging front end
// Assumes: Parallel register port already decoded from the serial interface
// Notes:   Derived controls lag register contents by one clock
//
// Behaviour
// (R1) Format field picks 8+6, 7+7 or 4+4+4+2 output word layout.
// (R2) Invert bit inverts converted output code polarity.
// (R3) External reference bit powers down clamp DAC and floats its output.
// (R4) DAC range bit, default one, selects supply or top-reference span.
// (R5) Latency field adds zero to three converter periods of delay.
// (R6) Converter period is two master clocks, three in mode 3.
// (R7) Four-bit DAC code, default all ones, sets clamp reference level.
// (R8) Reset timing field advances one, normal, retards one or two clocks.
// (R9) Mono channel field picks red, green or blue; code three reserved.
// (R10) Any write to software reset register resets every cell; the code keeps the derived controls and the pin synchroniser unreset.
// (R11) Any write to cycle reset register returns colour counter to red.
// (R12) Line-sequential bit selects line-by-line colour operation.
// (R13) Line-sequential forces mono select to one and channel to red.
// (R14) Line-sequential disables green and blue gain amplifiers.
// (R15) Auto-cycle bit makes shared pin step colours, else clamp input.
// (R16) While auto-cycling the pin does not clamp; internal bit governs.
// (R17) Forced-mux bit lets forced colour drive input mux alone.
// (R18) Internal clamp bit enables clamping in line-sequential auto-cycle.
// (R19) Forced colour codes red, green, blue; code three reserved.
// (R20) Host configures fields by writing codes to register addresses.
// (R21) Single-colour select: zero colour, one monochrome.
// (R22) Software reset restores defaults before the next access.
// (R23) Reset registers give one strobe and store nothing readable.
`timescale 1ns/1ps
`include "afe_consts.svh"
module afe_setup_control_regs
    import afe_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        reset_i,
    // Register port
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [5:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    output logic [7:0]       rdata_o,
    output logic             rdata_valid_o,
    // Device-level settings held elsewhere
    input  wire logic        mono_select_i,
    input  wire logic        mode3_i,
    // Shared clamp / cycle pin
    input  wire logic        clamp_cycle_pin_i,
    // Converter samples
    input  wire afe_sample_s sample_i,
    // Strobes
    output logic             soft_reset_o,
    output logic             cycle_reset_o,
    // Derived controls
    output afe_ctrl_s        ctrl_o,
    // Multiplexed output word
    output logic [7:0]       op_data_o,
    output logic             op_valid_o,
    output logic             op_first_o
);
    typedef struct packed {
        afe_fmt_s    fmt;
        afe_clamp_s  clamp;
        afe_lseq_s   lseq;
        afe_colour_t cycle_colour;
        logic        pin_prev;
        logic        srst_strobe;
        logic        cyc_strobe;
        logic [7:0]  rdata;
        logic        rvalid;
        afe_ctrl_s   ctrl;
    } afe_state_s;

    afe_state_s st_q;
    afe_state_s st_d;
    logic       pin_level;
    logic       sub_reset;

    function automatic afe_colour_t colour_step(input afe_colour_t c);
        if (c == `AFE_COL_RED) begin
            colour_step = `AFE_COL_GREEN;
        end else if (c == `AFE_COL_GREEN) begin
            colour_step = `AFE_COL_BLUE;
        end else begin
            colour_step = `AFE_COL_RED;
        end
    endfunction

    function automatic afe_state_s reset_state();
        reset_state       = '0;
        reset_state.fmt   = afe_fmt_s'(`AFE_FMT_RESET);
        reset_state.clamp = afe_clamp_s'(`AFE_CLAMP_RESET);
        reset_state.lseq  = afe_lseq_s'(`AFE_LSEQ_RESET);
        reset_state.cycle_colour = `AFE_COL_RED;
    endfunction

    // The output pipe restarts with every software reset as well; the pin synchroniser does not
    assign sub_reset = reset_i | st_q.srst_strobe; // [R10]

    afe_bit_sync u_pin_sync (
        .clk_i   (clk_i),
        .reset_i (reset_i),
        .pin_i   (clamp_cycle_pin_i),
        .level_o (pin_level)
    );

    afe_output_pipe #(
        .DEPTH (`AFE_TAP_DEPTH)
    ) u_output_pipe (
        .clk_i     (clk_i),
        .reset_i   (sub_reset),
        .invert_i  (st_q.ctrl.invert),
        .latency_i (st_q.ctrl.latency),
        .period_i  (st_q.ctrl.adc_period),
        .format_i  (st_q.ctrl.format_sel),
        .sample_i  (sample_i),
        .data_o    (op_data_o),
        .valid_o   (op_valid_o),
        .first_o   (op_first_o)
    );

    always_comb begin
        logic      auto_on;
        logic      step;
        afe_ctrl_s ctrl_keep;
        auto_on = st_q.lseq.line_seq & st_q.lseq.autocycle;
        ctrl_keep = '0;
        step    = pin_level & ~st_q.pin_prev;
        st_d    = st_q;
        st_d.pin_prev    = pin_level;
        st_d.srst_strobe = 1'b0;
        st_d.cyc_strobe  = 1'b0;
        st_d.rvalid      = rd_en_i;
        st_d.rdata       = `AFE_READ_ZERO;

        // Pin pulses step the colour only in line-sequential auto-cycle
        if (auto_on && step) begin
            st_d.cycle_colour = colour_step(st_q.cycle_colour); // [R15]
        end

        // Register writes
        if (wr_en_i) begin
            if (addr_i == `AFE_ADDR_FMT) begin
                st_d.fmt      = afe_fmt_s'(wdata_i); // [R20]
                st_d.fmt.rsvd = 1'b0;
            end else if (addr_i == `AFE_ADDR_CLAMP) begin
                st_d.clamp = afe_clamp_s'(wdata_i);
            end else if (addr_i == `AFE_ADDR_LSEQ) begin
                st_d.lseq = afe_lseq_s'(wdata_i);
            end else if (addr_i == `AFE_ADDR_CYCRST) begin
                st_d.cycle_colour = `AFE_COL_RED; // [R11]
                st_d.cyc_strobe   = 1'b1;         // [R23]
            end
        end

        // Register reads; strobe and unmapped addresses read zero
        if (rd_en_i) begin
            if (addr_i == `AFE_ADDR_FMT) begin
                st_d.rdata = st_q.fmt;
            end else if (addr_i == `AFE_ADDR_CLAMP) begin
                st_d.rdata = st_q.clamp;
            end else if (addr_i == `AFE_ADDR_LSEQ) begin
                st_d.rdata = st_q.lseq;
            end else begin
                st_d.rdata = `AFE_READ_ZERO; // [R23]
            end
        end

        // Derived controls, registered so every output leaves a flop
        st_d.ctrl.format_sel     = st_q.fmt.format_sel;   // [R1]
        st_d.ctrl.invert         = st_q.fmt.invert;       // [R2]
        st_d.ctrl.dac_power_down = st_q.fmt.ref_external; // [R3]
        st_d.ctrl.dac_drive_en   = ~st_q.fmt.ref_external; // [R3]
        st_d.ctrl.dac_range      = st_q.fmt.dac_range;    // [R4]
        st_d.ctrl.latency        = st_q.fmt.latency;      // [R5]
        st_d.ctrl.adc_period     = mode3_i ? `AFE_PER_MODE3 : `AFE_PER_NORMAL; // [R6]
        st_d.ctrl.dac_code       = st_q.clamp.dac_code;   // [R7]
        st_d.ctrl.cds_adjust     = st_q.clamp.cds_adjust; // [R8]
        st_d.ctrl.gb_pga_off     = st_q.lseq.line_seq;    // [R14]

        if (st_q.lseq.line_seq) begin
            st_d.ctrl.mono_eff      = 1'b1;         // [R12] [R13]
            st_d.ctrl.mono_pick_eff = `AFE_COL_RED; // [R13]
        end else begin
            st_d.ctrl.mono_eff      = mono_select_i;        // [R21]
            st_d.ctrl.mono_pick_eff = st_q.clamp.mono_pick; // [R9]
        end

        // Clamp source: internal bit in auto-cycle, else the pin level
        st_d.ctrl.pin_is_clamp = ~auto_on; // [R15]
        if (auto_on) begin
            st_d.ctrl.clamp_en = st_q.lseq.internal_clamp; // [R16] [R18]
        end else begin
            st_d.ctrl.clamp_en = pin_level;
        end

        // Gain/offset mux follows the mono pick, the cycle counter or internal colour
        if (!st_q.lseq.line_seq) begin
            st_d.ctrl.gain_mux = st_d.ctrl.mono_pick_eff;
        end else if (st_q.lseq.autocycle) begin
            st_d.ctrl.gain_mux = st_q.cycle_colour;
        end else begin
            st_d.ctrl.gain_mux = st_q.lseq.internal_colour;
        end

        // Input mux may be forced apart from gain and offset muxes
        if (st_q.lseq.line_seq && st_q.lseq.forced_mux) begin
            st_d.ctrl.input_mux = st_q.lseq.forced_colour; // [R17] [R19]
        end else begin
            st_d.ctrl.input_mux = st_d.ctrl.gain_mux;
        end

        // A software reset write wins over everything else except the derived controls, pin_prev and rvalid
        // Derived controls keep their one-clock lag, so they never drop to zero
        if (wr_en_i && (addr_i == `AFE_ADDR_SRST)) begin
            ctrl_keep        = st_d.ctrl;
            st_d             = reset_state(); // [R10] [R22]
            st_d.ctrl        = ctrl_keep;
            st_d.pin_prev    = pin_level;
            st_d.srst_strobe = 1'b1;          // [R23]
            st_d.rvalid      = rd_en_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (reset_i) begin
            st_q <= reset_state();
        end else begin
            st_q <= st_d;
        end
    end

    assign rdata_o       = st_q.rdata;
    assign rdata_valid_o = st_q.rvalid;
    assign soft_reset_o  = st_q.srst_strobe;
    assign cycle_reset_o = st_q.cyc_strobe;
    assign ctrl_o        = st_q.ctrl;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (reset_i);

    AST_SRST_DEFAULTS: assert property ( // [R22]
        wr_en_i && addr_i == `AFE_ADDR_SRST |=> st_q.fmt == afe_fmt_s'(`AFE_FMT_RESET)
            && st_q.clamp == afe_clamp_s'(`AFE_CLAMP_RESET) && st_q.lseq == '0)
        else $error("software reset did not restore defaults");

    AST_SRST_STROBE: assert property ( // [R23]
        wr_en_i && addr_i == `AFE_ADDR_SRST |=> soft_reset_o ##1 (!soft_reset_o
            || $past(wr_en_i && addr_i == `AFE_ADDR_SRST)))
        else $error("software reset strobe not a single pulse");

    AST_CYCLE_TO_RED: assert property ( // [R11]
        wr_en_i && addr_i == `AFE_ADDR_CYCRST |=> st_q.cycle_colour == `AFE_COL_RED
            && cycle_reset_o)
        else $error("cycle reset did not return colour to red");

    AST_CYCLE_STEP: assert property ( // [R15]
        st_q.lseq.line_seq && st_q.lseq.autocycle && pin_level && !st_q.pin_prev && !wr_en_i
            |=> st_q.cycle_colour == colour_step($past(st_q.cycle_colour)))
        else $error("pin pulse did not step colour");

    AST_LSEQ_FORCE: assert property ( // [R13]
        st_q.lseq.line_seq |=> ctrl_o.mono_eff && ctrl_o.mono_pick_eff == `AFE_COL_RED
            && ctrl_o.gb_pga_off)
        else $error("line-sequential forcing missing");

    AST_INTERNAL_CLAMP: assert property ( // [R18]
        st_q.lseq.line_seq && st_q.lseq.autocycle
            |=> ctrl_o.clamp_en == $past(st_q.lseq.internal_clamp) && !ctrl_o.pin_is_clamp)
        else $error("clamp not governed by internal bit");

    AST_FORCED_MUX: assert property ( // [R17]
        st_q.lseq.line_seq && st_q.lseq.forced_mux
            |=> ctrl_o.input_mux == $past(st_q.lseq.forced_colour))
        else $error("forced colour not on input mux");

    AST_PERIOD: assert property ( // [R6]
        mode3_i |=> ctrl_o.adc_period == `AFE_PER_MODE3)
        else $error("mode 3 converter period wrong");

    AST_DAC_FLOAT: assert property ( // [R3]
        st_q.fmt.ref_external |=> ctrl_o.dac_power_down && !ctrl_o.dac_drive_en)
        else $error("clamp DAC not floated");

    AST_NORMAL_MONO: assert property ( // [R21]
        !st_q.lseq.line_seq |=> ctrl_o.mono_eff == $past(mono_select_i))
        else $error("mono select not passed through");

    AST_DAC_DRIVE: assert property ( // [R3]
        !st_q.fmt.ref_external |=> ctrl_o.dac_drive_en && !ctrl_o.dac_power_down)
        else $error("clamp DAC not driving");

    COV_SRST: cover property (wr_en_i && addr_i == `AFE_ADDR_SRST ##1 soft_reset_o);
    COV_CYCLE_WRAP: cover property (st_q.cycle_colour == `AFE_COL_BLUE
        ##[1:20] st_q.cycle_colour == `AFE_COL_RED);
    COV_FOUR_PIECE: cover property (op_first_o && ctrl_o.format_sel == `AFE_OF_4P4P4P2);
endmodule

/* tb/afe_host_model.sv */
// Purpose: Host model that writes and reads the setup registers
// Assumes: Parallel register port, one access per task call
// Notes:   Address and data show a changing pattern between accesses
`timescale 1ns/1ps
module afe_host_model (
    // Clock
    input  wire logic       clk_i,
    // Register port
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic [5:0]      addr_o,
    output logic [7:0]      wdata_o,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rdata_valid_i
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o  = 6'h3F;
        wdata_o = 8'h00;
    end

    // One write; a write to the reset address triggers the reset
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i);
        #1;
        wr_en_o = 1'b1;
        addr_o  = a;
        wdata_o = d;
        @(posedge clk_i);
        #1;
        wr_en_o = 1'b0;
        addr_o  = ~a;
        wdata_o = ~d;
    endtask

    // One read; data taken at the edge where valid is registered
    task automatic rd(input logic [5:0] a, output logic [7:0] d);
        @(posedge clk_i);
        #1;
        rd_en_o = 1'b1;
        addr_o  = a;
        @(posedge clk_i);
        #1;
        d       = (rdata_valid_i === 1'b1) ? rdata_i : 8'hXX;
        rd_en_o = 1'b0;
        addr_o  = ~a;
    endtask
endmodule

/* tb/tb_top.sv */
// Purpose: Self-checking bench of the front-end setup control block
// Assumes: Stimulus 1 ns after the rising edge, fixed xorshift seed
// Notes:   Expected values come from bench functions only
`timescale 1ns/1ps
`include "afe_consts.svh"
module tb_top
    import afe_pkg::*;
;
    logic        clk_i, reset_i, wr_en, rd_en, rd_v, mono_sel, mode3, pin;
    logic        srst, crst, op_v, op_f;
    logic [5:0]  addr;
    logic [7:0]  wdata, rdata, op_data, got, d2, d3;
    logic [13:0] code;
    logic [15:0] nib;
    logic [31:0] seed;
    afe_sample_s smp;
    afe_ctrl_s   ctrl;
    int          err_total, num_checks;

    afe_setup_control_regs uut (
        .clk_i(clk_i), .reset_i(reset_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata), .rdata_valid_o(rd_v),
        .mono_select_i(mono_sel), .mode3_i(mode3), .clamp_cycle_pin_i(pin),
        .sample_i(smp), .soft_reset_o(srst), .cycle_reset_o(crst), .ctrl_o(ctrl),
        .op_data_o(op_data), .op_valid_o(op_v), .op_first_o(op_f));

    afe_host_model host (
        .clk_i(clk_i), .wr_en_o(wr_en), .rd_en_o(rd_en), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata), .rdata_valid_i(rd_v));

    function automatic logic [7:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed[7:0];
    endfunction

    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic summarize();
        if (err_total == 0 && num_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    initial begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    // Whole run needs well under 1000 cycles
    initial begin
        #(100 * 4000);
        err_total++;
        summarize();
    end

    initial begin
        reset_i = 1'b1;
        mono_sel = 1'b0;
        mode3 = 1'b0;
        pin = 1'b0;
        smp = '0;
        seed = 32'h9c08;
        err_total = 0;
        num_checks = 0;
        repeat (3) @(posedge clk_i);
        #1;
        reset_i = 1'b0;
        host.rd(`AFE_ADDR_FMT, got);
        chk("fmt reset", `AFE_FMT_RESET, got);
        host.rd(`AFE_ADDR_CLAMP, got);
        chk("clamp reset", `AFE_CLAMP_RESET, got);
        host.rd(`AFE_ADDR_LSEQ, got);
        chk("lseq reset", `AFE_LSEQ_RESET, got);
        host.rd(`AFE_ADDR_SRST, got);
        chk("srst read", `AFE_READ_ZERO, got);
        host.rd(`AFE_ADDR_CYCRST, got);
        chk("cycrst read", `AFE_READ_ZERO, got);
        host.rd(6'h3F, got);
        chk("unmapped read", `AFE_READ_ZERO, got);
        // Random fields, every 2-bit code forced across the loop
        for (int i = 0; i < 8; i++) begin
            d2 = (i == 0) ? 8'hFF : xs();
            d3 = (i == 0) ? 8'h00 : xs();
            d2[1:0] = i[1:0];
            d2[7:6] = i[2:1];
            d3[5:4] = i[1:0];
            d3[7:6] = i[1:0];
            mode3 = seed[9];
            mono_sel = seed[11];
            host.wr(`AFE_ADDR_FMT, d2);
            host.wr(`AFE_ADDR_CLAMP, d3);
            host.rd(`AFE_ADDR_FMT, got);
            chk("fmt readback", d2 & 8'hEF, got);
            host.rd(`AFE_ADDR_CLAMP, got);
            chk("clamp readback", d3, got);
            chk("format_sel", d2[1:0], ctrl.format_sel);
            chk("invert", d2[2], ctrl.invert);
            chk("dac_power_down", d2[3], ctrl.dac_power_down);
            chk("dac_drive_en", !d2[3], ctrl.dac_drive_en);
            chk("dac_range", d2[5], ctrl.dac_range);
            chk("latency", d2[7:6], ctrl.latency);
            chk("adc_period", mode3 ? `AFE_PER_MODE3 : `AFE_PER_NORMAL, ctrl.adc_period);
            chk("dac_code", d3[3:0], ctrl.dac_code);
            chk("cds_adjust", d3[5:4], ctrl.cds_adjust);
            chk("mono_pick_eff", d3[7:6], ctrl.mono_pick_eff);
            chk("mono_eff", mono_sel, ctrl.mono_eff);
        end
        // Line-sequential with forced blue input, internal colour green
        host.wr(`AFE_ADDR_LSEQ, 8'h95);
        host.rd(`AFE_ADDR_LSEQ, got);
        chk("lseq readback", 8'h95, got);
        chk("forced mono", 8'h01, ctrl.mono_eff);
        chk("forced chan", `AFE_COL_RED, ctrl.mono_pick_eff);
        chk("gb_pga_off", 8'h01, ctrl.gb_pga_off);
        chk("input_mux forced", `AFE_COL_BLUE, ctrl.input_mux);
        chk("gain_mux internal", `AFE_COL_GREEN, ctrl.gain_mux);
        chk("pin_is_clamp", 8'h01, ctrl.pin_is_clamp);
        // Auto-cycle with internal clamp on, then off
        host.wr(`AFE_ADDR_LSEQ, 8'h0B);
        host.rd(`AFE_ADDR_LSEQ, got);
        chk("pin not clamp", 8'h00, ctrl.pin_is_clamp);
        chk("clamp_en on", 8'h01, ctrl.clamp_en);
        host.wr(`AFE_ADDR_LSEQ, 8'h03);
        host.rd(`AFE_ADDR_LSEQ, got);
        chk("clamp_en off", 8'h00, ctrl.clamp_en);
        for (int i = 1; i < 4; i++) begin
            pin = 1'b1;
            repeat (3) @(posedge clk_i);
            #1;
            chk("pin clamp ignored", 8'h00, ctrl.clamp_en);
            pin = 1'b0;
            repeat (7) @(posedge clk_i);
            #1;
            chk("cycle colour", 8'(i % 3), ctrl.input_mux);
        end
        pin = 1'b1;
        repeat (3) @(posedge clk_i);
        #1;
        pin = 1'b0;
        host.wr(`AFE_ADDR_CYCRST, xs());
        chk("cycle strobe", 8'h01, crst);
        repeat (8) @(posedge clk_i);
        #1;
        chk("cycle reset red", `AFE_COL_RED, ctrl.input_mux);
        chk("cycle strobe gone", 8'h00, crst);
        // Output word 8+6, inverted, no added latency
        host.wr(`AFE_ADDR_FMT, 8'h04);
        repeat (2) @(posedge clk_i);
        #1;
        d2 = xs();
        d3 = xs();
        code = {d2[5:0], d3};
        smp = {1'b1, code};
        @(posedge clk_i);
        #1;
        smp.valid = 1'b0;
        chk("first piece flag", 8'h01, {op_f, op_v} == 2'b11);
        chk("first piece", ~code[13:6], op_data);
        @(posedge clk_i);
        #1;
        chk("second piece", {~code[5:0], 2'b00}, op_data);
        // Output word 4+4+4+2, one converter period of latency
        host.wr(`AFE_ADDR_FMT, 8'h43);
        repeat (2) @(posedge clk_i);
        #1;
        code = {d3[5:0], d2};
        smp = {1'b1, code};
        @(posedge clk_i);
        #1;
        smp.valid = 1'b0;
        repeat (mode3 ? 3 : 2) @(posedge clk_i);
        #1;
        for (int k = 0; k < 4; k++) begin
            nib = {code, 2'b00} << (4 * k);
            chk("nibble first", 8'(k == 0), op_f);
            chk("nibble piece", {nib[15:12], 4'h0}, op_data);
            @(posedge clk_i);
            #1;
        end
        // Software reset with arbitrary data
        host.wr(`AFE_ADDR_SRST, xs());
        chk("soft strobe", 8'h01, srst);
        host.rd(`AFE_ADDR_FMT, got);
        chk("fmt after srst", `AFE_FMT_RESET, got);
        host.rd(`AFE_ADDR_LSEQ, got);
        chk("lseq after srst", `AFE_LSEQ_RESET, got);
        summarize();
    end
endmodule
